// ---- fss_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link; its clock idles high and runs only inside a frame.
module fss_host_model (
  output logic serial_clk_out,
  output logic frame_sync_n_out,
  output logic serial_data_out
);
  initial begin
    serial_clk_out = 1'b1;
    frame_sync_n_out = 1'b1;
    serial_data_out = 1'b0;
  end
  // Bits change while the clock is high, so each is settled at its falling edge.
  task automatic send_word(input logic [15:0] w);
    #7 frame_sync_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_out = w[i];
      #32 serial_clk_out = 1'b0;
      #32 serial_clk_out = 1'b1;
    end
    frame_sync_n_out = 1'b1;
    // The line is released; show the inverse so a late sample cannot pass.
    serial_data_out = ~w[0];
    #64;
  endtask
endmodule // fss_host_model
`default_nettype wire

// ---- fss_pkg.sv ----
package fss_pkg;

  // Command word layout: four address bits above twelve data bits.
  localparam int CMD_W = 16;
  localparam int CMD_NIB_HI = 15;
  localparam int CMD_NIB_LO = 12;
  localparam int DATA_HI = 11;
  localparam int BITCNT_W = 4;
  localparam logic [BITCNT_W-1:0] BITCNT_LAST = 4'hF;

  // Address nibbles of the command words.
  localparam logic [3:0] NIB_CONTROL = 4'h0;
  localparam logic [3:0] NIB_STEP_COUNT = 4'h1;
  localparam logic [3:0] NIB_STEP_LOW = 4'h2;
  localparam logic [3:0] NIB_STEP_HIGH = 4'h3;
  localparam logic [3:0] NIB_START_LOW = 4'hC;
  localparam logic [3:0] NIB_START_HIGH = 4'hD;
  localparam logic [1:0] DWELL_PREFIX = 2'h1;

  // Bit positions inside command words.
  localparam int CTRL_FULL_WORD_BIT = 11;
  localparam int CTRL_STEP_SRC_BIT = 5;
  localparam int STEP_DIR_BIT = 11;
  localparam int DWELL_UNIT_BIT = 13;
  localparam int DWELL_MULT_HI = 12;
  localparam int DWELL_MULT_LO = 11;

  // Widths of the profile settings.
  localparam int FREQ_W = 24;
  localparam int HALF_W = 12;
  localparam int STEP_W = 23;
  localparam int STEP_HIGH_W = 11;
  localparam int COUNT_W = 12;
  localparam int DWELL_W = 11;
  localparam int PRESCALE_W = 9;

  // Time-base multipliers, stored as the last prescaler count.
  localparam logic [PRESCALE_W-1:0] MULT_X1_LAST = 9'h000;
  localparam logic [PRESCALE_W-1:0] MULT_X5_LAST = 9'h004;
  localparam logic [PRESCALE_W-1:0] MULT_X100_LAST = 9'h063;
  localparam logic [PRESCALE_W-1:0] MULT_X500_LAST = 9'h1F3;

  // Reset values of the profile.
  localparam logic [FREQ_W-1:0] FREQ_RESET = 24'h000000;
  localparam logic [STEP_W-1:0] STEP_RESET = 23'h000000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h002;
  localparam logic [DWELL_W-1:0] DWELL_RESET = 11'h002;

  typedef struct packed {
    logic [FREQ_W-1:0] start_freq_word;
    logic [STEP_W-1:0] step_value;
    logic step_down;
    logic [COUNT_W-1:0] step_count;
    logic dwell_in_clocks;
    logic [1:0] dwell_mult;
    logic [DWELL_W-1:0] dwell_interval;
  } fss_profile_t;

  typedef enum logic [1:0] {
    FSS_IDLE,
    FSS_RUN,
    FSS_DONE
  } fss_state_t;

endpackage

// ---- fss_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module fss_sequencer
  import fss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic frame_sync_n_in,
  input wire logic serial_data_in,
  input wire logic trigger_in,
  input wire logic output_cycle_in,
  output logic [FREQ_W-1:0] freq_word_out,
  output logic scan_active_out,
  output logic scan_done_out,
  output logic step_pulse_out
);

  // Serial link side: words are assembled on the host's serial clock.
  // Only the finished word and a toggle leave that domain.
  logic [CMD_W-1:0] link_word;
  logic link_toggle;

  fss_serial_rx u_rx (
    .serial_clk_in(serial_clk_in),
    .reset_in(reset_in),
    .frame_sync_n_in(frame_sync_n_in),
    .serial_data_in(serial_data_in),
    .word_out(link_word),
    .word_toggle_out(link_toggle)
  );

  // The word toggle and the trigger pin both come from outside this clock,
  // so they pass two flip-flops before anything looks at them.
  logic [1:0] sync_bits;

  fss_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .async_in({link_toggle, trigger_in}),
    .sync_out(sync_bits)
  );

  wire logic toggle_sync = sync_bits[1];
  wire logic trigger_sync = sync_bits[0];

  logic toggle_seen_reg;
  logic trigger_prev_reg;

  // Edge detection works on the synchronised copies only. Both history bits
  // reset to the idle level of their source, low, so releasing reset cannot
  // fake a trigger edge or a fresh command word.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      toggle_seen_reg <= 1'b0;
      trigger_prev_reg <= 1'b0;
    end else begin
      toggle_seen_reg <= toggle_sync;
      trigger_prev_reg <= trigger_sync;
    end
  end

  wire logic word_valid = toggle_sync ^ toggle_seen_reg;
  wire logic trigger_rise = trigger_sync && !trigger_prev_reg;

  // The link word stays put for at least sixteen serial clocks after its
  // toggle, far longer than the synchroniser delay, so it is read directly.
  wire logic [3:0] cmd_nibble = link_word[CMD_NIB_HI:CMD_NIB_LO];
  wire logic [HALF_W-1:0] cmd_data = link_word[DATA_HI:0];
  // Limitation: the scheme needs one word time of sixteen serial clocks to
  // outlast about four master clocks. A serial clock many times faster than
  // the master clock would let a new word overwrite one that the core has
  // not yet taken.

  // Command decoding. Each setting has its own strobe; unknown nibbles fall
  // through every compare and change nothing.
  wire logic wr_control = word_valid && (cmd_nibble == NIB_CONTROL);
  wire logic wr_count = word_valid && (cmd_nibble == NIB_STEP_COUNT);
  wire logic wr_step_low = word_valid && (cmd_nibble == NIB_STEP_LOW);
  wire logic wr_step_high = word_valid && (cmd_nibble == NIB_STEP_HIGH);
  wire logic wr_start_low = word_valid && (cmd_nibble == NIB_START_LOW);
  wire logic wr_start_high = word_valid && (cmd_nibble == NIB_START_HIGH);
  wire logic wr_dwell = word_valid &&
    (cmd_nibble[3:2] == DWELL_PREFIX);

  // Control bits picked out of the control word. Only the two bits that this
  // block acts on are kept; the output options in the same word belong to
  // the waveform path, outside this block.
  logic full_word_load_reg;
  logic step_source_select_reg;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      full_word_load_reg <= 1'b0;
      step_source_select_reg <= 1'b0;
    end else if (wr_control) begin
      full_word_load_reg <= cmd_data[CTRL_FULL_WORD_BIT];
      step_source_select_reg <= cmd_data[CTRL_STEP_SRC_BIT];
    end
  end

  // Start frequency. In full-word mode the low half waits in a holding
  // register and both halves land together with the high write, so a scan
  // never starts from half an update. In halves mode each write lands alone.
  // A high write without a pending low half changes only the upper half.
  fss_profile_t profile_reg;
  logic [HALF_W-1:0] start_low_hold_reg;
  logic start_low_pending_reg;

  wire logic start_low_direct = wr_start_low && !full_word_load_reg;
  wire logic start_low_held = wr_start_low && full_word_load_reg;
  wire logic start_high_commit = wr_start_high && full_word_load_reg &&
    start_low_pending_reg;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      start_low_hold_reg <= '0;
      start_low_pending_reg <= 1'b0;
    end else if (start_low_held) begin
      start_low_hold_reg <= cmd_data;
      start_low_pending_reg <= 1'b1;
    end else if (wr_start_high || wr_control) begin
      start_low_pending_reg <= 1'b0;
    end
  end

  // Profile register file, written by the decoded commands.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      profile_reg.start_freq_word <= FREQ_RESET;
      profile_reg.step_value <= STEP_RESET;
      profile_reg.step_down <= 1'b0;
      profile_reg.step_count <= COUNT_RESET;
      profile_reg.dwell_in_clocks <= 1'b0;
      profile_reg.dwell_mult <= '0;
      profile_reg.dwell_interval <= DWELL_RESET;
    end else begin
      if (start_low_direct) begin
        profile_reg.start_freq_word[HALF_W-1:0] <= cmd_data;
      end
      if (wr_start_high) begin
        profile_reg.start_freq_word[FREQ_W-1:HALF_W] <= cmd_data;
      end
      if (start_high_commit) begin
        profile_reg.start_freq_word[HALF_W-1:0] <= start_low_hold_reg;
      end
      if (wr_step_low) begin
        profile_reg.step_value[HALF_W-1:0] <= cmd_data;
      end
      if (wr_step_high) begin
        profile_reg.step_value[STEP_W-1:HALF_W] <= cmd_data[STEP_HIGH_W-1:0];
        profile_reg.step_down <= cmd_data[STEP_DIR_BIT];
      end
      if (wr_count) begin
        profile_reg.step_count <= cmd_data;
      end
      if (wr_dwell) begin
        profile_reg.dwell_in_clocks <= link_word[DWELL_UNIT_BIT];
        profile_reg.dwell_mult <= link_word[DWELL_MULT_HI:DWELL_MULT_LO];
        profile_reg.dwell_interval <= link_word[DWELL_W-1:0];
      end
    end
  end

  // Time-base multiplier, as the terminal count of the prescaler. Storing
  // the last count rather than the factor keeps the wrap test a plain
  // equality, and the times-one setting wraps on every unit.
  logic [PRESCALE_W-1:0] mult_last;

  always_comb begin
    case (profile_reg.dwell_mult)
      2'h0: mult_last = MULT_X1_LAST;
      2'h1: mult_last = MULT_X5_LAST;
      2'h2: mult_last = MULT_X100_LAST;
      default: mult_last = MULT_X500_LAST;
    endcase
  end

  // Sequencer state.
  fss_state_t state_reg;
  fss_state_t state_next;
  logic [FREQ_W-1:0] freq_reg;
  logic [COUNT_W-1:0] steps_done_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [DWELL_W-1:0] dwell_cnt_reg;

  // A dwell unit is one master clock or one output waveform cycle; the
  // same prescaler serves both so the multiplier acts alike on each.
  // The output-cycle pulse is made on this clock, so it needs no synchroniser.
  wire logic unit_tick = profile_reg.dwell_in_clocks || output_cycle_in;
  wire logic running = (state_reg == FSS_RUN);
  wire logic internal_mode = !step_source_select_reg;
  wire logic prescale_wrap = unit_tick && (prescale_reg == mult_last);
  wire logic base_tick = running && internal_mode && prescale_wrap;
  wire logic dwell_end = base_tick &&
    (dwell_cnt_reg == profile_reg.dwell_interval - 1'b1);

  // Counts below two are not guarded: a step count of zero wraps through
  // the whole step counter before the scan ends, and a dwell count of zero
  // waits the full range of the dwell counter. The host keeps both at two
  // or more.
  // In external mode a rising trigger edge during a scan is a step; in
  // internal mode the dwell timer steps, and a trigger edge restarts.
  wire logic ext_step = running && step_source_select_reg && trigger_rise;
  wire logic start_scan = trigger_rise && !ext_step;
  wire logic do_step = running && (ext_step || dwell_end) && !start_scan;
  wire logic last_step = (steps_done_reg + 1'b1) == profile_reg.step_count;

  // Next frequency: the step is unsigned, the direction bit picks the sign.
  // The word wraps modulo its width if a scan runs past either end.
  wire logic [FREQ_W-1:0] step_ext = {1'b0, profile_reg.step_value};
  wire logic [FREQ_W-1:0] freq_step = profile_reg.step_down ?
    freq_reg - step_ext : freq_reg + step_ext;

  // State transitions. A trigger edge in the middle of an internal-mode scan
  // restarts it from the start frequency, trading an abort input for a
  // simpler control path.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSS_IDLE: begin
        if (start_scan) begin
          state_next = FSS_RUN;
        end
      end
      FSS_RUN: begin
        if (start_scan) begin
          state_next = FSS_RUN;
        end else if (do_step && last_step) begin
          state_next = FSS_DONE;
        end
      end
      FSS_DONE: begin
        if (start_scan) begin
          state_next = FSS_RUN;
        end
      end
      default: state_next = FSS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= FSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Frequency word and step counter. The start frequency is shown for a
  // full dwell before the first step, so a scan lasts count dwells and shows count plus one words.
  // After the last step nothing loads freq_reg again until the next start.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      freq_reg <= FREQ_RESET;
      steps_done_reg <= '0;
    end else if (start_scan) begin
      freq_reg <= profile_reg.start_freq_word;
      steps_done_reg <= '0;
    end else if (do_step) begin
      freq_reg <= freq_step;
      steps_done_reg <= steps_done_reg + 1'b1;
    end
  end

  // Dwell timer: prescaler counts units, dwell counter counts base intervals.
  // Both restart at every scan start and every step, so each frequency of an
  // internal-mode scan gets a whole dwell; in external mode base_tick is masked. Outside a
  // scan the timer is held at zero so no stale count shortens the first dwell.
  wire logic timer_clear = start_scan || do_step || !running;

  // Prescaler and dwell counter.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prescale_reg <= '0;
      dwell_cnt_reg <= '0;
    end else if (timer_clear) begin
      prescale_reg <= '0;
      dwell_cnt_reg <= '0;
    end else if (unit_tick) begin
      if (prescale_wrap) begin
        prescale_reg <= '0;
        dwell_cnt_reg <= dwell_cnt_reg + 1'b1;
      end else begin
        prescale_reg <= prescale_reg + 1'b1;
      end
    end
  end

  // Status flags come from flip-flops loaded with the next state, so they
  // switch on the same edge as the state itself and never glitch.
  logic scan_active_reg;
  logic scan_done_reg;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      scan_active_reg <= 1'b0;
      scan_done_reg <= 1'b0;
    end else begin
      scan_active_reg <= (state_next == FSS_RUN);
      scan_done_reg <= (state_next == FSS_DONE);
    end
  end

  // Registered outputs; the last frequency simply stays in freq_reg.
  // The step pulse rises on the same edge as the new frequency word.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      step_pulse_out <= 1'b0;
    end else begin
      step_pulse_out <= do_step;
    end
  end

  assign freq_word_out = freq_reg;
  assign scan_active_out = scan_active_reg;
  assign scan_done_out = scan_done_reg;

endmodule // fss_sequencer

`default_nettype wire

// ---- fss_sequencer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the scan outputs against the trigger pin and each other.
module fss_sequencer_asserts
  import fss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic serial_clk_in,
  input wire logic frame_sync_n_in,
  input wire logic serial_data_in,
  input wire logic trigger_in,
  input wire logic output_cycle_in,
  input wire logic [FREQ_W-1:0] freq_word_out,
  input wire logic scan_active_out,
  input wire logic scan_done_out,
  input wire logic step_pulse_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // A trigger edge while not scanning, and the minimum dwell after a start.
  sequence s_trig_idle;
    $rose(trigger_in) && !scan_active_out;
  endsequence
  sequence s_quiet2;
    !step_pulse_out ##1 !step_pulse_out;
  endsequence
  a_start_on_trig: assert property (s_trig_idle |-> ##[1:8] scan_active_out)
    else $error("scan did not start after trigger");
  a_first_dwell: assert property ($rose(scan_active_out) |-> s_quiet2)
    else $error("step came before the start dwell ended");
  a_pulse_single: assert property (step_pulse_out |=> !step_pulse_out)
    else $error("step pulse longer than one cycle");
  a_step_in_scan: assert property (step_pulse_out |-> $past(scan_active_out))
    else $error("step pulse outside a scan");
  a_freq_steps: assert property (($changed(freq_word_out) && !$rose(scan_active_out) &&
    !($past(trigger_in, 3) && !$past(trigger_in, 4))) |-> step_pulse_out)
    else $error("frequency changed without a step pulse");
  a_done_excl: assert property (!(scan_done_out && scan_active_out))
    else $error("done and active together");
  a_done_hold: assert property ((scan_done_out && $past(scan_done_out)) |-> $stable(freq_word_out))
    else $error("frequency moved after the scan ended");
  a_done_exit: assert property ($fell(scan_done_out) |-> scan_active_out)
    else $error("done cleared without a new scan");
  a_done_no_step: assert property ((scan_done_out && $past(scan_done_out)) |-> !step_pulse_out)
    else $error("step pulse after the scan ended");
endmodule // fss_sequencer_asserts

bind fss_sequencer fss_sequencer_asserts u_chk (.core_clk_in, .reset_in, .serial_clk_in,
  .frame_sync_n_in, .serial_data_in, .trigger_in, .output_cycle_in, .freq_word_out,
  .scan_active_out, .scan_done_out, .step_pulse_out);
`default_nettype wire

// ---- fss_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fss_sequencer_tb
  import fss_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic trigger_in = 1'b0;
  logic output_cycle_in = 1'b0;
  logic [1:0] oc_cnt = 2'h0;
  wire logic serial_clk, frame_sync_n, serial_data;
  logic [FREQ_W-1:0] freq_word_out;
  logic scan_active_out, scan_done_out, step_pulse_out;
  int mismatches = 0;
  int check_count = 0;

  always #5 core_clk_in = ~core_clk_in;
  // Output waveform cycles arrive every fourth master clock.
  always @(posedge core_clk_in) begin
    oc_cnt <= oc_cnt + 2'h1;
    output_cycle_in <= (oc_cnt == 2'h3);
  end

  fss_host_model host (.serial_clk_out(serial_clk), .frame_sync_n_out(frame_sync_n),
    .serial_data_out(serial_data));
  fss_sequencer dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .serial_clk_in(serial_clk), .frame_sync_n_in(frame_sync_n), .serial_data_in(serial_data),
    .trigger_in(trigger_in), .output_cycle_in(output_cycle_in), .freq_word_out(freq_word_out),
    .scan_active_out(scan_active_out), .scan_done_out(scan_done_out),
    .step_pulse_out(step_pulse_out));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] ctrl(input bit fw, input bit ext);
    return 16'h00D3 | (16'(fw) << CTRL_FULL_WORD_BIT) | (16'(ext) << CTRL_STEP_SRC_BIT);
  endfunction

  function automatic logic [15:0] dwl(input bit unit, input logic [1:0] m, input int n);
    return {2'b01, unit, m, 11'(n)};
  endfunction

  // Sends the words, then leaves time for them to cross into the master clock.
  task automatic prog(input logic [15:0] ws[$]);
    foreach (ws[i]) host.send_word(ws[i]);
    repeat (6) @(posedge core_clk_in);
  endtask

  // Counts master clocks until the chosen output is high; the trigger drops after four.
  task automatic wait_for(input bit want_step, output int n);
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
      if (n == 4) trigger_in <= 1'b0;
      #1;
    end while ((want_step ? step_pulse_out : scan_active_out) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      results();
    end
    if (trigger_in) begin
      @(posedge core_clk_in);
      trigger_in <= 1'b0;
    end
  endtask

  // Starts a scan and follows every step; the first dwell has an unknown offset.
  task automatic run_scan(input logic [23:0] start, input logic [23:0] step, input bit down,
      input int count, input int dwell, input bit ext);
    logic [23:0] exp;
    int n;
    exp = start;
    @(posedge core_clk_in);
    trigger_in <= 1'b1;
    wait_for(1'b0, n);
    check("start freq", freq_word_out, start);
    for (int k = 1; k <= count; k++) begin
      if (ext) begin
        repeat (3) @(posedge core_clk_in);
        trigger_in <= 1'b1;
      end
      wait_for(1'b1, n);
      exp = down ? exp - step : exp + step;
      check("step freq", freq_word_out, exp);
      if (k > 1 && !ext) check("dwell", 24'(n), 24'(dwell));
    end
    check("done", {23'h0, scan_done_out}, 24'h1);
    check("active", {23'h0, scan_active_out}, 24'h0);
    repeat (dwell + 8) @(posedge core_clk_in);
    #1 check("held freq", freq_word_out, exp);
    check("held pulse", {23'h0, step_pulse_out}, 24'h0);
  endtask

  task automatic sc_basic();
    prog('{ctrl(0, 0), 16'hC123, 16'hD456, 16'h2010, 16'h3000, 16'h1002, dwl(1, 0, 3)});
    run_scan(24'h456123, 24'h10, 0, 2, 3, 0);
  endtask

  // Only the upper start half is rewritten, and the scan falls.
  task automatic sc_down();
    prog('{16'hD7A0, 16'h3801, 16'h1003, dwl(1, 1, 2)});
    run_scan(24'h7A0123, 24'h001010, 1, 3, 10, 0);
  endtask

  task automatic sc_mults();
    for (int m = 2; m <= 3; m++) begin
      prog('{16'h3000, 16'h1002, dwl(1, 2'(m), 2)});
      run_scan(24'h7A0123, 24'h10, 0, 2, (m == 2) ? 200 : 1000, 0);
    end
  endtask

  task automatic sc_full_word();
    prog('{ctrl(1, 0), 16'hCABC, 16'hD0DE, dwl(1, 0, 2)});
    run_scan(24'h0DEABC, 24'h10, 0, 2, 2, 0);
  endtask

  // Ten output cycles of four master clocks each.
  task automatic sc_out_cycles();
    prog('{ctrl(0, 0), dwl(0, 1, 2)});
    run_scan(24'h0DEABC, 24'h10, 0, 2, 40, 0);
  endtask

  task automatic sc_external();
    prog('{ctrl(0, 1), 16'h1003});
    run_scan(24'h0DEABC, 24'h10, 0, 3, 0, 1);
  endtask

  initial begin
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    check("reset freq", freq_word_out, FREQ_RESET);
    sc_basic();
    sc_down();
    sc_mults();
    sc_full_word();
    sc_out_cycles();
    sc_external();
    results();
  end
endmodule // fss_sequencer_tb
`default_nettype wire

// ---- fss_serial_rx.sv ----
`timescale 1ns/1ps
`default_nettype none

// Serial command receiver, clocked by the host's serial clock.
module fss_serial_rx
  import fss_pkg::*;
(
  input wire logic serial_clk_in,
  input wire logic reset_in,
  input wire logic frame_sync_n_in,
  input wire logic serial_data_in,
  output logic [CMD_W-1:0] word_out,
  output logic word_toggle_out
);

  logic [BITCNT_W-1:0] bit_cnt_reg;
  logic [CMD_W-2:0] shift_reg;
  wire logic last_bit = (bit_cnt_reg == BITCNT_LAST) && !frame_sync_n_in;

  // The bit counter is cleared by the frame line itself, since the serial
  // clock may stop between frames and cannot be relied on to end a word.
  always_ff @(negedge serial_clk_in or posedge reset_in or posedge frame_sync_n_in) begin
    if (reset_in || frame_sync_n_in) begin
      bit_cnt_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // Data arrives most significant bit first; the word is held stable for a
  // whole further word, long enough for the core to sample it after the toggle.
  always_ff @(negedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift_reg <= '0;
      word_out <= '0;
      word_toggle_out <= 1'b0;
    end else begin
      shift_reg <= {shift_reg[CMD_W-3:0], serial_data_in};
      if (last_bit) begin
        word_out <= {shift_reg, serial_data_in};
        word_toggle_out <= !word_toggle_out;
      end
    end
  end

endmodule // fss_serial_rx

`default_nettype wire

// ---- fss_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; only the second stage is visible outside.
module fss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule // fss_sync

`default_nettype wire
